// [core/fpsi_cfg.svh]
`ifndef FPSI_CFG_SVH
`define FPSI_CFG_SVH
// system clock rate and flash timing
`define FPSI_CLK_HZ 100000000
`define FPSI_SLOW_MS 1000
`define FPSI_FAST_MS 500
`define FPSI_FAST_ON_PCT 20
`define FPSI_SLOW_ON_PCT 50
`define FPSI_RELOAD_MS 30
// image layout: bar graphs of 12 lamps plus one digit
`define FPSI_BAR_LEN 12
`define FPSI_NUM_BARS 3
`define FPSI_SEG_LEN 8
`define FPSI_IMG_LEN 44
// shift clock divider (half period is this count plus one system cycle)
`define FPSI_SCK_HALF 8'h32
// lamp positions inside the image
`define FPSI_L_ENABLED 0
`define FPSI_L_TONE_ACC 1
`define FPSI_L_KEYPAD 2
`define FPSI_L_IDENT 3
`define FPSI_L_SHORT_KEY 4
`define FPSI_L_PATCH 5
`define FPSI_L_USER_DIAL 6
`define FPSI_L_EMERG_DIAL 7
`define FPSI_L_LINK1 8
`define FPSI_L_LINK2 9
`define FPSI_L_UNLOCKED 10
`define FPSI_L_PROGRAM 11
`define FPSI_L_RX_SQ 12
`define FPSI_L_LINK1_SQ 13
`define FPSI_L_LINK2_SQ 14
`define FPSI_L_TONE_IN 15
`define FPSI_L_RING 16
`define FPSI_L_CTRL_SQ 17
`define FPSI_NUM_MODED 10
`endif

// [core/fpsi_pkg.sv]
package fpsi_pkg;
  typedef enum logic [1:0] {
    FPSI_OFF = 2'h0,
    FPSI_ON = 2'h1,
    FPSI_SLOW = 2'h2,
    FPSI_FAST = 2'h3
  } fpsi_lamp_e;
  typedef enum logic [1:0] {
    FPSI_IDLE,
    FPSI_LOW,
    FPSI_HIGH,
    FPSI_LATCH
  } fpsi_shift_e;
endpackage

// [core/fpsi_top.sv]
`timescale 1ns/1ns
`include "fpsi_cfg.svh"
module fpsi_top #(
  parameter int unsigned CLK_HZ = `FPSI_CLK_HZ
) (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic DISPLAY_ON_I,
  input wire logic RESET_BUTTON_I,
  input wire logic SYS_ENABLED_I,
  input wire logic TIMEOUT_EXPIRED_I,
  input wire logic [1:0] TONE_ACCESS_MODE_I,
  input wire logic KEYPAD_ACCESS_EN_I,
  input wire logic KEYPAD_ACCESS_UP_I,
  input wire logic ID_REQUIRED_I,
  input wire logic ID_PENDING_I,
  input wire logic ID_ANXIOUS_I,
  input wire logic SHORT_KEYUP_I,
  input wire logic PATCH_EN_I,
  input wire logic PATCH_LD_BLOCKED_I,
  input wire logic PATCH_BUSY_I,
  input wire logic DIAL_BANK_EN_I,
  input wire logic DIAL_BANK_LOCKED_I,
  input wire logic DIAL_BANK_BUSY_I,
  input wire logic EMERG_DIAL_EN_I,
  input wire logic EMERG_DIAL_BUSY_I,
  input wire logic [1:0] LINK_EN_I,
  input wire logic [1:0] LINK_ON_I,
  input wire logic [1:0] LINK_TX_I,
  input wire logic UNLOCKED_I,
  input wire logic NVM_WRITING_I,
  input wire logic RX_SQUELCH_I,
  input wire logic [1:0] LINK_SQUELCH_I,
  input wire logic MAIN_TONE_I,
  input wire logic USER_TONE_I,
  input wire logic RING_I,
  input wire logic CTRL_SQUELCH_I,
  input wire logic [`FPSI_BAR_LEN-1:0] BAR_AUX_I,
  input wire logic [`FPSI_SEG_LEN-1:0] DIGIT_SEG_I,
  output logic POWER_LAMP_O,
  output logic MCU_RESET_O,
  output logic SR_DATA_O,
  output logic SR_CLK_O,
  output logic SR_LATCH_O,
  output logic DISPLAY_PWR_O
);
  localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * `FPSI_SLOW_MS;
  // divide first: the product would overflow 32 bits at the full clock rate
  localparam int unsigned SLOW_ON = SLOW_CYC / 100 * `FPSI_SLOW_ON_PCT;
  localparam int unsigned FAST_CYC = CLK_HZ / 1000 * `FPSI_FAST_MS;
  localparam int unsigned FAST_ON = FAST_CYC / 100 * `FPSI_FAST_ON_PCT;
  localparam int unsigned RELOAD_CYC = CLK_HZ / 1000 * `FPSI_RELOAD_MS;
  localparam int IMG = `FPSI_IMG_LEN;

  function automatic logic lamp_bit(input logic [1:0] code, input logic slow,
                                    input logic fast);
    case (code)
      fpsi_pkg::FPSI_OFF: lamp_bit = 1'b0;
      fpsi_pkg::FPSI_ON: lamp_bit = 1'b1;
      fpsi_pkg::FPSI_SLOW: lamp_bit = slow;
      default: lamp_bit = fast;
    endcase
  endfunction

  // shared timebase
  logic [26:0] slow_cnt_q, slow_cnt_d;
  logic [25:0] fast_cnt_q, fast_cnt_d;
  logic [21:0] reload_cnt_q, reload_cnt_d;
  logic slow_ph, fast_ph, reload_tick;

  always_comb
  begin
    slow_cnt_d = (slow_cnt_q == 27'(SLOW_CYC - 1)) ? '0 : slow_cnt_q + 27'h1;
    fast_cnt_d = (fast_cnt_q == 26'(FAST_CYC - 1)) ? '0 : fast_cnt_q + 26'h1;
    reload_tick = (reload_cnt_q == 22'(RELOAD_CYC - 1));
    reload_cnt_d = reload_tick ? '0 : reload_cnt_q + 22'h1;
    slow_ph = (slow_cnt_q < 27'(SLOW_ON));
    fast_ph = (fast_cnt_q < 26'(FAST_ON));
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      slow_cnt_q <= '0;
      fast_cnt_q <= '0;
      reload_cnt_q <= '0;
    end
    else
    begin
      slow_cnt_q <= slow_cnt_d;
      fast_cnt_q <= fast_cnt_d;
      reload_cnt_q <= reload_cnt_d;
    end
  end

  // lamp codes
  logic [1:0] code [`FPSI_NUM_MODED];
  always_comb
  begin
    code[0] = TIMEOUT_EXPIRED_I ? fpsi_pkg::FPSI_SLOW :
              (SYS_ENABLED_I ? fpsi_pkg::FPSI_ON : fpsi_pkg::FPSI_OFF);
    code[1] = TONE_ACCESS_MODE_I;
    code[2] = !KEYPAD_ACCESS_EN_I ? fpsi_pkg::FPSI_OFF :
              (KEYPAD_ACCESS_UP_I ? fpsi_pkg::FPSI_FAST : fpsi_pkg::FPSI_ON);
    code[3] = !ID_REQUIRED_I ? fpsi_pkg::FPSI_OFF : ID_ANXIOUS_I ? fpsi_pkg::FPSI_FAST :
              ID_PENDING_I ? fpsi_pkg::FPSI_SLOW : fpsi_pkg::FPSI_ON;
    code[4] = SHORT_KEYUP_I ? fpsi_pkg::FPSI_FAST : fpsi_pkg::FPSI_OFF;
    code[5] = PATCH_BUSY_I ? fpsi_pkg::FPSI_FAST : !PATCH_EN_I ? fpsi_pkg::FPSI_OFF :
              PATCH_LD_BLOCKED_I ? fpsi_pkg::FPSI_SLOW : fpsi_pkg::FPSI_ON;
    code[6] = DIAL_BANK_BUSY_I ? fpsi_pkg::FPSI_FAST : !DIAL_BANK_EN_I ? fpsi_pkg::FPSI_OFF :
              DIAL_BANK_LOCKED_I ? fpsi_pkg::FPSI_SLOW : fpsi_pkg::FPSI_ON;
    code[7] = EMERG_DIAL_BUSY_I ? fpsi_pkg::FPSI_FAST :
              (EMERG_DIAL_EN_I ? fpsi_pkg::FPSI_ON : fpsi_pkg::FPSI_OFF);
    code[8] = '0;
    code[9] = '0;
    for (int k = 0; k < 2; k++)
    begin
      code[8 + k] = !LINK_EN_I[k] ? fpsi_pkg::FPSI_OFF : !LINK_ON_I[k] ? fpsi_pkg::FPSI_ON :
                    LINK_TX_I[k] ? fpsi_pkg::FPSI_FAST : fpsi_pkg::FPSI_SLOW;
    end
  end

  // image built at reload
  logic [IMG-1:0] image;
  genvar g;
  generate
    for (g = 0; g < `FPSI_NUM_MODED; g++)
    begin : g_lamp
      assign image[g] = lamp_bit(code[g], slow_ph, fast_ph);
    end
  endgenerate
  assign image[`FPSI_L_UNLOCKED] = UNLOCKED_I;
  assign image[`FPSI_L_PROGRAM] = NVM_WRITING_I;
  assign image[`FPSI_L_RX_SQ] = RX_SQUELCH_I;
  assign image[`FPSI_L_LINK1_SQ] = LINK_SQUELCH_I[0];
  assign image[`FPSI_L_LINK2_SQ] = LINK_SQUELCH_I[1];
  assign image[`FPSI_L_TONE_IN] = MAIN_TONE_I | USER_TONE_I;
  assign image[`FPSI_L_RING] = RING_I;
  assign image[`FPSI_L_CTRL_SQ] = CTRL_SQUELCH_I;
  assign image[2*`FPSI_BAR_LEN-1:`FPSI_L_CTRL_SQ+1] = '0;
  assign image[3*`FPSI_BAR_LEN-1:2*`FPSI_BAR_LEN] = BAR_AUX_I;
  assign image[IMG-1:3*`FPSI_BAR_LEN] = DIGIT_SEG_I;

  // serial loader
  fpsi_pkg::fpsi_shift_e st_q, st_d;
  logic [IMG-1:0] sh_q, sh_d;
  logic [5:0] bit_q, bit_d;
  logic [7:0] div_q, div_d;
  logic data_q, data_d, clk_q, clk_d, lat_q, lat_d;
  logic div_end;

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    data_d = data_q;
    clk_d = clk_q;
    lat_d = 1'b0;
    div_end = (div_q == `FPSI_SCK_HALF);
    div_d = (st_q == fpsi_pkg::FPSI_IDLE || div_end) ? 8'h0 : div_q + 8'h1;
    case (st_q)
      fpsi_pkg::FPSI_IDLE:
      begin
        clk_d = 1'b0;
        if (reload_tick)
        begin
          sh_d = DISPLAY_ON_I ? image : '0;
          bit_d = '0;
          st_d = fpsi_pkg::FPSI_LOW;
        end
      end
      fpsi_pkg::FPSI_LOW:
        if (div_end)
        begin
          data_d = sh_q[IMG-1];
          clk_d = 1'b0;
          st_d = fpsi_pkg::FPSI_HIGH;
        end
      fpsi_pkg::FPSI_HIGH:
        if (div_end)
        begin
          clk_d = 1'b1;
          sh_d = {sh_q[IMG-2:0], 1'b0};
          bit_d = bit_q + 6'h1;
          st_d = (bit_q == 6'(IMG - 1)) ? fpsi_pkg::FPSI_LATCH : fpsi_pkg::FPSI_LOW;
        end
      fpsi_pkg::FPSI_LATCH:
        if (div_end)
        begin
          clk_d = 1'b0;
          lat_d = 1'b1;
          st_d = fpsi_pkg::FPSI_IDLE;
        end
      default: st_d = fpsi_pkg::FPSI_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      st_q <= fpsi_pkg::FPSI_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      div_q <= '0;
      data_q <= 1'b0;
      clk_q <= 1'b0;
      lat_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      div_q <= div_d;
      data_q <= data_d;
      clk_q <= clk_d;
      lat_q <= lat_d;
    end
  end

  assign SR_DATA_O = data_q;
  assign SR_CLK_O = clk_q;
  assign SR_LATCH_O = lat_q;
  assign DISPLAY_PWR_O = DISPLAY_ON_I;
  assign POWER_LAMP_O = 1'b1;
  assign MCU_RESET_O = RESET_BUTTON_I | SRST_I;

  property p_slow_duty;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (slow_cnt_q == 27'(longint'(SLOW_CYC) * `FPSI_SLOW_ON_PCT / 100 - 1)) |->
        slow_ph ##1 !slow_ph;
  endproperty
  a_slow_duty: assert property (p_slow_duty) else $error("slow flash phase wrong");

  property p_fast_duty;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (fast_cnt_q == 26'(longint'(FAST_CYC) * `FPSI_FAST_ON_PCT / 100 - 1)) |->
        fast_ph ##1 !fast_ph;
  endproperty
  a_fast_duty: assert property (p_fast_duty) else $error("fast flash on too long");

  property p_blank;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (st_q == fpsi_pkg::FPSI_IDLE && reload_tick && !DISPLAY_ON_I) |=> (sh_q == '0);
  endproperty
  a_blank: assert property (p_blank) else $error("display not blanked");

  property p_reset_out;
    @(posedge CLOCK_I) disable iff (SRST_I) RESET_BUTTON_I |-> MCU_RESET_O;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("micro reset not forced");

  property p_reload_start;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (reload_tick && st_q == fpsi_pkg::FPSI_IDLE) |=> (st_q == fpsi_pkg::FPSI_LOW);
  endproperty
  a_reload_start: assert property (p_reload_start) else $error("reload missed");

  property p_latch_end;
    @(posedge CLOCK_I) disable iff (SRST_I)
      SR_LATCH_O |-> (st_q == fpsi_pkg::FPSI_IDLE && bit_q == 6'(IMG));
  endproperty
  a_latch_end: assert property (p_latch_end) else $error("latch before full image");

  property p_latch_pulse;
    @(posedge CLOCK_I) disable iff (SRST_I)
      SR_LATCH_O |=> !SR_LATCH_O;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch longer than one cycle");

  property p_data_hold;
    @(posedge CLOCK_I) disable iff (SRST_I)
      SR_CLK_O |-> $stable(SR_DATA_O);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("shift data moved while clock high");

  property p_enabled_lamp;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (TIMEOUT_EXPIRED_I) |-> (image[`FPSI_L_ENABLED] == slow_ph);
  endproperty
  a_enabled_lamp: assert property (p_enabled_lamp) else $error("timeout not slow flash");

  property p_tone_in;
    @(posedge CLOCK_I) disable iff (SRST_I)
      image[`FPSI_L_TONE_IN] == (MAIN_TONE_I || USER_TONE_I);
  endproperty
  a_tone_in: assert property (p_tone_in) else $error("tone input lamp wrong");
endmodule

// [bench/fpsi_panel_model.sv]
`timescale 1ns/1ns
// display board: shift chain clocked on the rising shift clock, copied to lamps on latch
module fpsi_panel_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic data_i,
  input wire logic sck_i,
  input wire logic latch_i,
  output logic [43:0] shown_o,
  output logic [7:0] bits_o,
  output logic long_latch_o
);
  logic [43:0] chain_q;
  logic [7:0] cnt_q;
  logic sck_q;
  logic latch_q;
  always_ff @(posedge clk_i)
  begin
    sck_q <= sck_i;
    latch_q <= latch_i;
    if (rst_i)
    begin
      chain_q <= 44'h0;
      cnt_q <= 8'h0;
      shown_o <= 44'h0;
      bits_o <= 8'h0;
      long_latch_o <= 1'b0;
    end
    else
    begin
      if (sck_i && !sck_q)
      begin
        chain_q <= {chain_q[42:0], data_i};
        cnt_q <= cnt_q + 8'h1;
      end
      // board image is 44 lamps: three 12-lamp bars and one digit
      if (latch_i)
      begin
        shown_o <= chain_q;
        bits_o <= cnt_q;
        cnt_q <= 8'h0;
      end
      if (latch_i && latch_q)
        long_latch_o <= 1'b1;
    end
  end
endmodule

// [bench/front_panel_status_indicators_test.sv]
`timescale 1ns/1ns
`include "fpsi_cfg.svh"
module front_panel_status_indicators_test;
  logic clk = 1'b0, srst = 1'b1, disp = 1'b0, rbtn = 1'b0;
  logic sys_en = 1'b0, tmo = 1'b1, kp_en = 1'b1, kp_up = 1'b1;
  logic id_req = 1'b0, id_pend = 1'b1, id_anx = 1'b0, short_key = 1'b1;
  logic pt_en = 1'b0, pt_ld = 1'b1, pt_busy = 1'b0, db_en = 1'b1, db_lk = 1'b1, db_busy = 1'b0;
  logic em_en = 1'b0, em_busy = 1'b1, unl = 1'b0, nvm = 1'b1, rx_sq = 1'b1;
  logic m_tone = 1'b0, u_tone = 1'b1, ring = 1'b0, c_sq = 1'b1;
  logic [1:0] tone_mode = 2'h2, l_en = 2'h1, l_on = 2'h1, l_tx = 2'h0, l_sq = 2'h2;
  logic [11:0] aux = 12'ha5c;
  logic [7:0] dig = 8'h3d;
  logic pwr, mrst, sd, sck, slat, dpwr, long_l;
  logic [43:0] shown, exp;
  logic [7:0] nbits;
  int num_errors = 0, n_checks = 0, cyc = 0, lat_cyc = 0, prev_lat = 0;
  // timebase scaled down here so a whole fast flash period and the slow lit half fit in a short run
  localparam int unsigned SIM_HZ = 160_000;
  localparam int RELOAD = `FPSI_RELOAD_MS * (SIM_HZ / 1000);
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= srst ? 0 : cyc + 1;
  fpsi_top #(.CLK_HZ(SIM_HZ)) dut_u (.CLOCK_I(clk), .SRST_I(srst), .DISPLAY_ON_I(disp),
    .RESET_BUTTON_I(rbtn),
    .SYS_ENABLED_I(sys_en), .TIMEOUT_EXPIRED_I(tmo), .TONE_ACCESS_MODE_I(tone_mode),
    .KEYPAD_ACCESS_EN_I(kp_en), .KEYPAD_ACCESS_UP_I(kp_up), .ID_REQUIRED_I(id_req),
    .ID_PENDING_I(id_pend), .ID_ANXIOUS_I(id_anx), .SHORT_KEYUP_I(short_key),
    .PATCH_EN_I(pt_en), .PATCH_LD_BLOCKED_I(pt_ld), .PATCH_BUSY_I(pt_busy),
    .DIAL_BANK_EN_I(db_en), .DIAL_BANK_LOCKED_I(db_lk), .DIAL_BANK_BUSY_I(db_busy),
    .EMERG_DIAL_EN_I(em_en), .EMERG_DIAL_BUSY_I(em_busy), .LINK_EN_I(l_en),
    .LINK_ON_I(l_on), .LINK_TX_I(l_tx), .UNLOCKED_I(unl), .NVM_WRITING_I(nvm),
    .RX_SQUELCH_I(rx_sq), .LINK_SQUELCH_I(l_sq), .MAIN_TONE_I(m_tone), .USER_TONE_I(u_tone),
    .RING_I(ring), .CTRL_SQUELCH_I(c_sq), .BAR_AUX_I(aux), .DIGIT_SEG_I(dig),
    .POWER_LAMP_O(pwr), .MCU_RESET_O(mrst), .SR_DATA_O(sd), .SR_CLK_O(sck),
    .SR_LATCH_O(slat), .DISPLAY_PWR_O(dpwr));
  fpsi_panel_model board_u (.clk_i(clk), .rst_i(srst), .data_i(sd), .sck_i(sck),
    .latch_i(slat), .shown_o(shown), .bits_o(nbits), .long_latch_o(long_l));
  task automatic check(input string what, input logic [43:0] e, input logic [43:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // wait for one complete frame at the board, bounded past the reload period
  task automatic wait_frame();
    int n;
    n = 0;
    while (slat !== 1'b1 && n < 2 * RELOAD)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (slat !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH frame_latch expected 1 seen %b", slat);
    end
    lat_cyc = cyc;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial
  begin
    repeat (95_000) @(posedge clk);
    num_errors++;
    $display("MISMATCH watchdog expected frame seen none");
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    check("power_in_reset", 44'h1, 44'(pwr));
    check("mcu_reset_in_reset", 44'h1, 44'(mrst));
    check("serial_in_reset", 44'h0, 44'({sd, sck, slat}));
    @(posedge clk) srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("mcu_reset_idle", 44'h0, 44'(mrst));
    check("display_pwr_off", 44'h0, 44'(dpwr));
    check("power_display_off", 44'h1, 44'(pwr));
    @(posedge clk) rbtn <= 1'b1;
    @(posedge clk) #1;
    check("mcu_reset_button", 44'h1, 44'(mrst));
    @(posedge clk) rbtn <= 1'b0;
    disp <= 1'b1;
    @(posedge clk) #1;
    check("display_pwr_on", 44'h1, 44'(dpwr));
    check("mcu_reset_release", 44'h0, 44'(mrst));
    // first capture one reload period after reset, inside the lit part of both flashes
    exp = {dig, aux, 24'h0};
    exp[`FPSI_L_ENABLED] = 1'b1;
    exp[`FPSI_L_TONE_ACC] = 1'b1;
    exp[`FPSI_L_KEYPAD] = 1'b1;
    exp[`FPSI_L_SHORT_KEY] = 1'b1;
    exp[`FPSI_L_USER_DIAL] = 1'b1;
    exp[`FPSI_L_EMERG_DIAL] = 1'b1;
    exp[`FPSI_L_LINK1] = 1'b1;
    exp[`FPSI_L_PROGRAM] = 1'b1;
    exp[`FPSI_L_RX_SQ] = 1'b1;
    exp[`FPSI_L_LINK2_SQ] = 1'b1;
    exp[`FPSI_L_TONE_IN] = 1'b1;
    exp[`FPSI_L_CTRL_SQ] = 1'b1;
    wait_frame();
    check("lamp_image", exp, shown);
    check("bits_in_frame", 44'd44, 44'(nbits));
    check("latch_single_cycle", 44'h0, 44'(long_l));
    check("reload_window", 44'h1, 44'(lat_cyc >= RELOAD && lat_cyc < RELOAD + 5000));
    prev_lat = lat_cyc;
    // second set: a new state on every moded lamp, both flashes still lit
    @(posedge clk);
    sys_en <= 1'b1;
    tmo <= 1'b0;
    tone_mode <= 2'h3;
    kp_up <= 1'b0;
    id_req <= 1'b1;
    short_key <= 1'b0;
    pt_en <= 1'b1;
    pt_ld <= 1'b0;
    db_busy <= 1'b1;
    em_en <= 1'b1;
    em_busy <= 1'b0;
    l_en <= 2'h3;
    l_on <= 2'h2;
    l_tx <= 2'h2;
    unl <= 1'b1;
    nvm <= 1'b0;
    rx_sq <= 1'b0;
    l_sq <= 2'h1;
    m_tone <= 1'b1;
    u_tone <= 1'b0;
    ring <= 1'b1;
    c_sq <= 1'b0;
    wait_frame();
    exp = {dig, aux, 6'h0, 18'h1a7ef};
    check("lamp_set2", exp, shown);
    check("reload_period", 44'(RELOAD), 44'(lat_cyc - prev_lat));
    check("bits_set2", 44'd44, 44'(nbits));
    // display switched off: blank frame, power lamp stays lit
    @(posedge clk);
    disp <= 1'b0;
    wait_frame();
    check("display_pwr_blank", 44'h0, 44'(dpwr));
    check("power_display_blank", 44'h1, 44'(pwr));
    check("lamp_image_blank", 44'h0, shown);
    // next capture falls in the dark part of the fast flash
    @(posedge clk);
    disp <= 1'b1;
    pt_busy <= 1'b1;
    wait_frame();
    exp = {dig, aux, 6'h0, 18'h1a58d};
    check("lamp_fast_dark", exp, shown);
    // third set, captured later in the dark half of the slow flash
    @(posedge clk);
    tmo <= 1'b1;
    tone_mode <= 2'h1;
    kp_en <= 1'b0;
    id_anx <= 1'b1;
    short_key <= 1'b1;
    pt_busy <= 1'b0;
    pt_ld <= 1'b1;
    db_busy <= 1'b0;
    em_busy <= 1'b1;
    l_on <= 2'h1;
    l_tx <= 2'h0;
    unl <= 1'b0;
    nvm <= 1'b1;
    rx_sq <= 1'b1;
    l_sq <= 2'h2;
    m_tone <= 1'b0;
    ring <= 1'b0;
    c_sq <= 1'b1;
    aux <= 12'h5a3;
    dig <= 8'hc2;
    repeat (13) wait_frame();
    exp = {dig, aux, 6'h0, 18'h25a9a};
    check("lamp_slow_dark", exp, shown);
    check("lamp_slow_dark_inputs", 44'h1, 44'(exp[`FPSI_L_TONE_IN] == shown[`FPSI_L_TONE_IN]));
    check("latch_single_cycle_end", 44'h0, 44'(long_l));
    test_done();
  end
endmodule
